// ### design/clip_register_transfer.sv
`timescale 1ns/1ps
module clip_register_transfer #(
  parameter int ADDR_W = clip_xfer_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // dimension flag
  input  wire logic              mode_3d,
  // command port
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire clip_xfer_pkg::clip_op_t cmd_op,
  input  wire logic [3:0]        cmd_reg,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [4:0]        cmd_count,
  // command status
  output logic                   busy,
  output logic                   done,
  output logic                   cmd_error,
  // data sink pointer
  input  wire logic              sink_ptr_load,
  input  wire logic [ADDR_W-1:0] sink_ptr_value,
  output logic [ADDR_W-1:0]      sink_ptr,
  // stolen memory cycles
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [35:0]            mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [35:0]       mem_rdata,
  // register read-back for the pipeline
  input  wire logic [3:0]        peek_index,
  output logic [39:0]            peek_data
);
  if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 2 and 32");
  end

  typedef enum logic [1:0] {st_idle, st_issue, st_wait} seq_state_t;

  localparam int RW = clip_xfer_pkg::REG_W;
  localparam int CW = clip_xfer_pkg::COMP_W;
  localparam int HW = clip_xfer_pkg::HALF_W;

  seq_state_t                state;
  clip_xfer_pkg::clip_op_t   op;
  logic                      mode3;
  logic [3:0]                reg_no;
  logic [4:0]                left;
  logic                      phase;
  logic [ADDR_W-1:0]         addr_ptr;
  logic [RW-1:0]             regs [clip_xfer_pkg::NUM_PHYS];

  // command decode at the port
  wire cmd_fire   = cmd_valid && cmd_ready;
  wire cmd_plain  = cmd_op == clip_xfer_pkg::load_clip_absolute ||
                    cmd_op == clip_xfer_pkg::pop_clip_absolute ||
                    cmd_op == clip_xfer_pkg::store_clip_regs ||
                    cmd_op == clip_xfer_pkg::push_clip_regs;
  wire cmd_reject = mode_3d && !cmd_plain;
  wire [4:0] cmd_left = (cmd_count == 5'h0) ? clip_xfer_pkg::FULL_COUNT : cmd_count;

  // decode of the command in progress
  wire is_store = op == clip_xfer_pkg::store_clip_regs;
  wire is_push  = op == clip_xfer_pkg::push_clip_regs;
  wire is_pop   = op == clip_xfer_pkg::pop_clip_absolute ||
                  op == clip_xfer_pkg::pop_clip_relative ||
                  op == clip_xfer_pkg::pop_clip_size_absolute ||
                  op == clip_xfer_pkg::pop_clip_size_relative;
  wire is_wr    = is_store || is_push;
  wire is_rel   = op == clip_xfer_pkg::load_clip_relative || op == clip_xfer_pkg::pop_clip_relative;
  wire is_sabs  = op == clip_xfer_pkg::load_clip_size_absolute ||
                  op == clip_xfer_pkg::pop_clip_size_absolute;
  wire is_srel  = op == clip_xfer_pkg::load_clip_size_relative ||
                  op == clip_xfer_pkg::pop_clip_size_relative;
  wire is_size  = is_sabs || is_srel;
  wire [1:0] kind = is_srel ? clip_xfer_pkg::KIND_SIZE_REL :
                    is_sabs ? clip_xfer_pkg::KIND_SIZE :
                    is_rel  ? clip_xfer_pkg::KIND_REL : clip_xfer_pkg::KIND_ABS;

  // register number to physical halves; pairs 14..17 alias 0..7
  wire       quad   = reg_no >= clip_xfer_pkg::FIRST_QUAD;
  wire [3:0] lb_idx = quad ? {1'b0, reg_no[1:0], 1'b0} : {reg_no[3:1], 1'b0};
  wire [3:0] rt_idx = lb_idx | 4'h1;
  // pops meet the right-top word first since it went in last
  wire       hi_half  = mode3 && (phase ^ is_pop);
  wire       plain2   = !mode3 && !quad;
  wire [3:0] word_idx = plain2 ? reg_no : (hi_half ? rt_idx : lb_idx);
  wire       reg_last = !mode3 || phase;

  // word address: sink pushes post-increment, pops pre-decrement
  wire [ADDR_W-1:0] word_addr = is_pop  ? sink_ptr - ADDR_W'(1) :
                                is_push ? sink_ptr : addr_ptr;

  // outgoing word: low 18 bits of each 20-bit half
  wire [RW-1:0]  src_reg  = (word_idx < 4'hc) ? regs[word_idx] : clip_xfer_pkg::REG_RESET;
  wire [35:0]    src_word = {src_reg[CW +: HW], src_reg[0 +: HW]};

  // incoming word shaped by transfer form
  logic [RW-1:0] ext_val;
  logic [RW-1:0] rt_val;
  logic [RW-1:0] lb_val;
  wire  [RW-1:0] cur_point = regs[clip_xfer_pkg::CUR_POINT_IDX];

  clip_word_former u_former (
    .kind      (kind),
    .word      (mem_rdata),
    .cur_point (cur_point),
    .ext_val   (ext_val),
    .rt_val    (rt_val),
    .lb_val    (lb_val)
  );

  // write ports into the register file
  wire           word_ack = state == st_wait && mem_ack;
  wire           rd_ack   = word_ack && !is_wr;
  wire           pair_fill = quad || is_size;
  wire           wa_en    = rd_ack;
  wire [3:0]     wa_idx   = mode3 ? word_idx : (pair_fill ? rt_idx : reg_no);
  wire [RW-1:0]  wa_val   = mode3 ? ext_val : rt_val;
  wire           wb_en    = rd_ack && !mode3 && pair_fill;
  wire [3:0]     wb_idx   = lb_idx;
  wire [RW-1:0]  wb_val   = lb_val;

  // register storage, one entry per physical two-component register
  for (genvar i = 0; i < clip_xfer_pkg::NUM_PHYS; i++) begin : g_reg
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        regs[i] <= clip_xfer_pkg::REG_RESET;
      end else if (wa_en && wa_idx == 4'(i)) begin
        regs[i] <= wa_val;
      end else if (wb_en && wb_idx == 4'(i)) begin
        regs[i] <= wb_val;
      end
    end
  end

  // handshake outputs
  assign cmd_ready = state == st_idle;
  assign mem_req   = state == st_wait;
  assign busy      = state != st_idle;

  // sequencer: one issue cycle latches the word, then wait for the ack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= st_idle;
      op    <= clip_xfer_pkg::load_clip_absolute;
      mode3 <= 1'b0;
      reg_no <= 4'h0;
      left  <= 5'h0;
      phase <= 1'b0;
      done  <= 1'b0;
      cmd_error <= 1'b0;
    end else begin
      done      <= 1'b0;
      cmd_error <= 1'b0;
      case (state)
        st_idle: begin
          if (cmd_fire && cmd_reject) begin
            cmd_error <= 1'b1;
          end else if (cmd_fire) begin
            op     <= cmd_op;
            mode3  <= mode_3d;
            reg_no <= cmd_reg;
            left   <= cmd_left;
            phase  <= 1'b0;
            state  <= st_issue;
          end
        end
        st_issue: begin
          state <= st_wait;
        end
        st_wait: begin
          if (mem_ack) begin
            phase <= mode3 ? !phase : 1'b0;
            if (reg_last) begin
              reg_no <= is_pop ? reg_no - 4'h1 : reg_no + 4'h1;
              left   <= left - 5'h1;
            end
            if (reg_last && left == 5'h1) begin
              state <= st_idle;
              done  <= 1'b1;
            end else begin
              state <= st_issue;
            end
          end
        end
        default: begin
          state <= st_idle;
        end
      endcase
    end
  end

  // memory word latched in the issue cycle so address and data are flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_we    <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= 36'h0_0000_0000;
    end else if (state == st_issue) begin
      mem_we    <= is_wr;
      mem_addr  <= word_addr;
      mem_wdata <= is_wr ? src_word : 36'h0_0000_0000;
    end
  end

  // memory address for loads and stores; sink pointer moves per word
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_ptr <= '0;
      sink_ptr <= '0;
    end else begin
      if (cmd_fire && !cmd_reject) begin
        addr_ptr <= cmd_addr;
      end else if (word_ack && !is_push && !is_pop) begin
        addr_ptr <= addr_ptr + ADDR_W'(1);
      end
      // software may reseat the pointer only while idle
      if (state == st_idle && sink_ptr_load) begin
        sink_ptr <= sink_ptr_value;
      end else if (word_ack && is_push) begin
        sink_ptr <= sink_ptr + ADDR_W'(1);
      end else if (word_ack && is_pop) begin
        sink_ptr <= sink_ptr - ADDR_W'(1);
      end
    end
  end

  // read-back port; pair numbers read as zero here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      peek_data <= clip_xfer_pkg::REG_RESET;
    end else begin
      peek_data <= (peek_index < 4'hc) ? regs[peek_index] : clip_xfer_pkg::REG_RESET;
    end
  end

  // checks
  property p_reject_3d;
    @(posedge ref_clk) disable iff (rst)
      cmd_fire && mode_3d && !cmd_plain |=> cmd_error && !busy ##1 !mem_req;
  endproperty
  a_reject_3d: assert property (p_reject_3d) else $error("3D non-absolute form was not refused");

  property p_zero_count;
    @(posedge ref_clk) disable iff (rst)
      cmd_fire && !cmd_reject && cmd_count == 5'h0 |=> left == 5'h10;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero count did not mean sixteen");

  property p_push_ptr;
    @(posedge ref_clk) disable iff (rst)
      word_ack && is_push |=> sink_ptr == $past(sink_ptr) + ADDR_W'(1);
  endproperty
  a_push_ptr: assert property (p_push_ptr) else $error("sink pointer did not advance on push");

  property p_pop_addr;
    @(posedge ref_clk) disable iff (rst)
      word_ack && is_pop |-> mem_addr == sink_ptr - ADDR_W'(1) ##1 sink_ptr == $past(mem_addr);
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop did not pre-decrement the sink");

  property p_push_addr;
    @(posedge ref_clk) disable iff (rst)
      mem_req && is_push |-> mem_addr == sink_ptr && mem_we;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("push word not at sink pointer");

  property p_pop_descends;
    @(posedge ref_clk) disable iff (rst)
      word_ack && is_pop && reg_last && left > 5'h1 |=> reg_no == $past(reg_no) - 4'h1;
  endproperty
  a_pop_descends: assert property (p_pop_descends) else $error("pop did not step register down");

  property p_store_steps;
    @(posedge ref_clk) disable iff (rst)
      word_ack && is_store && !(reg_last && left == 5'h1) |=> ##2 mem_req && mem_addr == $past(mem_addr, 3) + ADDR_W'(1);
  endproperty
  a_store_steps: assert property (p_store_steps) else $error("store address did not step");

  property p_two_words_3d;
    @(posedge ref_clk) disable iff (rst)
      word_ack && mode3 && !phase |=> left == $past(left) && phase && busy;
  endproperty
  a_two_words_3d: assert property (p_two_words_3d) else $error("3D register used one word");

  property p_size_mirror;
    @(posedge ref_clk) disable iff (rst)
      wb_en && is_sabs |=> regs[$past(lb_idx)][CW +: CW] == -regs[$past(rt_idx)][CW +: CW] &&
                            regs[$past(lb_idx)][0 +: CW] == -regs[$past(rt_idx)][0 +: CW];
  endproperty
  a_size_mirror: assert property (p_size_mirror) else $error("size corner not mirrored");

  property p_quad_point;
    @(posedge ref_clk) disable iff (rst)
      wb_en && !is_size && lb_idx != clip_xfer_pkg::CUR_POINT_IDX |=> regs[$past(lb_idx)] == $past(cur_point);
  endproperty
  a_quad_point: assert property (p_quad_point) else $error("pair load lost current point");
endmodule : clip_register_transfer

// ### design/clip_xfer_pkg.sv
package clip_xfer_pkg;
  // memory word and register geometry
  localparam int WORD_W    = 36;
  localparam int HALF_W    = 18;
  localparam int COMP_W    = 20;
  localparam int REG_W     = 40;
  localparam int REG_NUM_W = 4;
  localparam int COUNT_W   = 5;
  localparam int NUM_PHYS  = 12;
  localparam int ADDR_W    = 18;

  // register numbering: 0..13 octal are two-component, 14..17 octal are pairs
  localparam logic [3:0]  FIRST_QUAD    = 4'hc;
  localparam logic [3:0]  CUR_POINT_IDX = 4'h0;
  localparam logic [4:0]  FULL_COUNT    = 5'h10;
  localparam logic [39:0] REG_RESET     = 40'h00_0000_0000;

  // how a fetched word is turned into register contents
  localparam logic [1:0] KIND_ABS      = 2'h0;
  localparam logic [1:0] KIND_REL      = 2'h1;
  localparam logic [1:0] KIND_SIZE     = 2'h2;
  localparam logic [1:0] KIND_SIZE_REL = 2'h3;

  // transfer commands
  typedef enum logic [3:0] {
    load_clip_absolute,
    load_clip_relative,
    load_clip_size_absolute,
    load_clip_size_relative,
    store_clip_regs,
    push_clip_regs,
    pop_clip_absolute,
    pop_clip_relative,
    pop_clip_size_absolute,
    pop_clip_size_relative
  } clip_op_t;
endpackage : clip_xfer_pkg

// ### design/clip_word_former.sv
`timescale 1ns/1ps
module clip_word_former (
  // transfer form and fetched word
  input  wire logic [1:0]  kind,
  input  wire logic [35:0] word,
  // current point
  input  wire logic [39:0] cur_point,
  // formed values
  output logic      [39:0] ext_val,
  output logic      [39:0] rt_val,
  output logic      [39:0] lb_val
);
  localparam int CW = clip_xfer_pkg::COMP_W;
  localparam int HW = clip_xfer_pkg::HALF_W;

  // one slice per coordinate: x in the upper half, y in the lower half
  for (genvar c = 0; c < 2; c++) begin : g_comp
    logic [CW-1:0] ext_c;
    logic [CW-1:0] cp_c;
    logic [CW-1:0] base_c;
    // 18-bit half sign-extended into the 20-bit component
    assign ext_c  = {{(CW-HW){word[c*HW+HW-1]}}, word[c*HW +: HW]};
    assign cp_c   = cur_point[c*CW +: CW];
    assign base_c = kind[0] ? cp_c : '0;
    assign ext_val[c*CW +: CW] = ext_c;
    // relative forms add the current point
    assign rt_val[c*CW +: CW]  = base_c + ext_c;
    // size forms mirror the corner, plain forms keep the current point
    assign lb_val[c*CW +: CW]  = kind[1] ? (base_c - ext_c) : cp_c;
  end
endmodule : clip_word_former

// ### testbench/clip_mem_model.sv
`timescale 1ns/1ps
module clip_mem_model #(
  parameter int ADDR_W = 6
) (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // stolen memory cycles
  input  wire logic              mem_req,
  input  wire logic              mem_we,
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic [35:0]       mem_wdata,
  output logic                   mem_ack,
  output logic [35:0]            mem_rdata
);
  logic [35:0] mem [2**ADDR_W];
  logic [1:0]  wait_left;

  // waits 0..3 cycles per word, so prompt and slow words mix
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 36'h0_0000_0000;
      wait_left <= 2'h0;
    end else if (mem_req && !mem_ack && wait_left == 2'h0) begin
      mem_ack   <= 1'b1;
      mem_rdata <= mem[mem_addr];
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
      end
    end else if (mem_req && !mem_ack) begin
      wait_left <= wait_left - 2'h1;
    end else begin
      // data is not held past the ack, so a late sample sees it toggle
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_left <= mem_addr[1:0] ^ mem_wdata[1:0];
    end
  end
endmodule : clip_mem_model

// ### testbench/test_clip_register_transfer.sv
`timescale 1ns/1ps
module test_clip_register_transfer;
  localparam int AW = 6;
  // design inputs, valued from time zero
  logic                    ref_clk = 1'b0, rst = 1'b1, mode_3d = 1'b0, cmd_valid = 1'b0, sink_ptr_load = 1'b0;
  clip_xfer_pkg::clip_op_t cmd_op = clip_xfer_pkg::load_clip_absolute;
  logic [3:0]              cmd_reg = 4'h0, peek_index = 4'h0;
  logic [4:0]              cmd_count = 5'h00;
  logic [AW-1:0]           cmd_addr = '0, sink_ptr_value = '0;
  // design outputs
  logic                    cmd_ready, busy, done, cmd_error, mem_req, mem_we, mem_ack;
  logic [AW-1:0]           sink_ptr, mem_addr;
  logic [35:0]             mem_wdata, mem_rdata;
  logic [39:0]             peek_data;
  // expected registers, memory and sink pointer
  logic [39:0]             er [12];
  logic [35:0]             em [2**AW];
  logic [AW-1:0]           esp = '0;
  int                      n_mismatch = 0, samples_checked = 0, seed = 95, i, m, op, r, c;
  // mode, op, register, address, count
  int plan [22][5] = '{'{0, 0, 0, 8, 0}, '{1, 1, 12, 0, 1}, '{1, 2, 14, 0, 1},
    '{1, 3, 15, 0, 1}, '{1, 7, 12, 0, 1}, '{1, 8, 13, 0, 1},
    '{1, 9, 14, 0, 1}, '{0, 1, 4, 30, 2}, '{0, 2, 14, 33, 1},
    '{0, 3, 13, 34, 2}, '{0, 4, 9, 40, 3}, '{1, 4, 12, 48, 2},
    '{0, 5, 6, 0, 3}, '{1, 5, 13, 0, 1}, '{1, 0, 13, 52, 1},
    '{1, 6, 13, 0, 1}, '{0, 5, 4, 0, 4}, '{0, 1, 6, 56, 3},
    '{0, 6, 7, 0, 2}, '{0, 7, 5, 0, 2}, '{0, 8, 15, 0, 1},
    '{0, 9, 13, 0, 1}};

  clip_register_transfer #(.ADDR_W(AW)) u_clip_register_transfer (
    .ref_clk, .rst, .mode_3d, .cmd_valid, .cmd_ready, .cmd_op, .cmd_reg, .cmd_addr, .cmd_count, .busy, .done,
    .cmd_error, .sink_ptr_load, .sink_ptr_value, .sink_ptr, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_rdata, .peek_index, .peek_data
  );
  clip_mem_model #(.ADDR_W(AW)) u_clip_mem_model (
    .ref_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata
  );

  // base plus or minus the sign-extended word halves, per component
  function automatic logic [39:0] shape(input logic [39:0] b, input logic [35:0] w, input logic neg);
    logic [19:0] x;
    logic [19:0] y;
    x = {{2{w[35]}}, w[35:18]};
    y = {{2{w[17]}}, w[17:0]};
    return neg ? {b[39:20] - x, b[19:0] - y} : {b[39:20] + x, b[19:0] + y};
  endfunction : shape

  task automatic check_val(input string what, input logic [39:0] exp, input logic [39:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // next word of a load or a pop; a pop steps the pointer back first
  task automatic get_word(input int op, inout logic [AW-1:0] a, output logic [35:0] w);
    if (op >= 6) begin
      esp = esp - 1'b1;
      w = em[esp];
    end else begin
      w = em[a];
      a = a + 1'b1;
    end
  endtask : get_word

  // expected effect of one command; pairs of a 4-part register are lb even, rt odd
  task automatic model_cmd(input int m, input int op, input logic [3:0] r, input logic [AW-1:0] a,
                           input int n, output logic err);
    logic [3:0]  lb;
    logic [3:0]  rt;
    logic [35:0] w;
    logic [39:0] cp;
    logic [39:0] base;
    int          fk;
    fk = (op >= 6) ? op - 6 : op;
    err = m != 0 && fk != 0 && op != 4 && op != 5;
    for (int k = 0; k < n && !err; k++) begin
      lb = (r >= 4'hc) ? {1'b0, r[1:0], 1'b0} : {r[3:1], 1'b0};
      rt = lb | 4'h1;
      if (r < 4'hc && m == 0 && fk != 2 && fk != 3) begin
        lb = r;
        rt = r;
      end
      cp = er[0];
      base = (fk == 1 || fk == 3) ? cp : 40'h00_0000_0000;
      if (op == 4 || op == 5) begin
        for (int j = 0; j <= m; j++) begin
          w = {er[j ? rt : lb][37:20], er[j ? rt : lb][17:0]};
          if (op == 4) begin
            em[a] = w;
            a = a + 1'b1;
          end else begin
            em[esp] = w;
            esp = esp + 1'b1;
          end
        end
      end else if (m != 0) begin
        get_word(op, a, w);
        er[op >= 6 ? rt : lb] = shape(40'h00_0000_0000, w, 1'b0);
        get_word(op, a, w);
        er[op >= 6 ? lb : rt] = shape(40'h00_0000_0000, w, 1'b0);
      end else begin
        get_word(op, a, w);
        er[rt] = shape(base, w, 1'b0);
        if (lb != rt) begin
          er[lb] = (fk < 2) ? cp : shape(base, w, 1'b1);
        end
      end
      r = (op >= 6) ? r - 4'h1 : r + 4'h1;
    end
  endtask : model_cmd

  // read back every register, then memory and the sink pointer
  task automatic check_all();
    for (int k = 0; k < 12; k++) begin
      @(posedge ref_clk);
      peek_index <= k[3:0];
      @(posedge ref_clk);
      #1;
      check_val("register", er[k], peek_data);
    end
    for (int k = 0; k < 2**AW; k++) begin
      check_val("memory word", 40'(em[k]), 40'(u_clip_mem_model.mem[k]));
    end
    check_val("sink pointer", 40'(esp), 40'(sink_ptr));
  endtask : check_all

  // load the sink pointer while idle
  task automatic set_sink(input int v);
    @(posedge ref_clk);
    sink_ptr_load  <= 1'b1;
    sink_ptr_value <= v[AW-1:0];
    @(posedge ref_clk);
    sink_ptr_load  <= 1'b0;
    esp = v[AW-1:0];
  endtask : set_sink

  // offer one command for one edge, then wait for done or refusal
  task automatic run(input int m, input int op, input int r, input int a, input int c);
    logic e;
    int   t;
    model_cmd(m, op, r[3:0], a[AW-1:0], (c == 0) ? 16 : c, e);
    @(posedge ref_clk);
    mode_3d   <= m[0];
    cmd_valid <= 1'b1;
    cmd_op    <= clip_xfer_pkg::clip_op_t'(op);
    cmd_reg   <= r[3:0];
    cmd_addr  <= a[AW-1:0];
    cmd_count <= c[4:0];
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    #1;
    check_val("busy", 40'(!e), 40'(busy));
    t = 0;
    while (t < 400 && done !== 1'b1 && cmd_error !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      t++;
    end
    check_val("cmd_error", 40'(e), 40'(cmd_error));
    check_val("done", 40'(!e), 40'(done));
    check_val("cmd_ready", 40'h1, 40'(cmd_ready));
    check_all();
  endtask : run

  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end

  // under two thousand cycles are planned; this cuts a hang short
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  // reset, directed table, then seeded random commands
  initial begin
    foreach (er[k]) er[k] = 40'h00_0000_0000;
    foreach (em[k]) begin
      em[k] = 36'({$random(seed), $random(seed)});
      u_clip_mem_model.mem[k] = em[k];
    end
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    check_all();
    set_sink(20);
    for (i = 0; i < 22; i++) begin
      run(plan[i][0], plan[i][1], plan[i][2], plan[i][3], plan[i][4]);
    end
    for (i = 0; i < 24; i++) begin
      m = $random(seed) & 1;
      op = {$random(seed)} % 10;
      c = (op inside {2, 3, 8, 9}) ? 1 : 1 + {$random(seed)} % 4;
      // 3D stays on pairs without wrapping; 2D stores and pushes stay on two-component registers
      if (m != 0) begin
        r = 12 + ((op >= 6) ? c - 1 : 0) + {$random(seed)} % (5 - c);
      end else if (op inside {2, 3, 8, 9}) begin
        r = 12 + {$random(seed)} % 4;
      end else if (op inside {4, 5}) begin
        r = {$random(seed)} % (13 - c);
      end else begin
        r = {$random(seed)} % 16;
      end
      run(m, op, r, {$random(seed)} % 64, c);
    end
    finish_test();
  end
endmodule : test_clip_register_transfer
